// ===== rtl/itd_pkg.sv
package itd_pkg;

  localparam int NWIN = 8;
  localparam logic [2:0] CWP_MAX = 3'h7;
  localparam logic [7:0] TT_INST_ACCESS = 8'h01;
  localparam logic [7:0] TT_ILLEGAL = 8'h02;
  localparam logic [7:0] TT_PRIV = 8'h03;
  localparam logic [7:0] TT_FP_DIS = 8'h04;
  localparam logic [7:0] TT_WIN_OVF = 8'h05;
  localparam logic [7:0] TT_WIN_UNF = 8'h06;
  localparam logic [7:0] TT_ALIGN = 8'h07;
  localparam logic [7:0] TT_FP_EXC = 8'h08;
  localparam logic [7:0] TT_DATA_ACCESS = 8'h09;
  localparam logic [7:0] TT_TAG_OVF = 8'h0a;
  localparam logic [7:0] TT_CP_DIS = 8'h24;
  localparam logic [7:0] TT_CP_EXC = 8'h28;
  localparam logic [7:0] TT_IRQ_BASE = 8'h10;
  localparam logic [7:0] TT_SW_BASE = 8'h80;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] RESET_NPC = 32'h0000_0004;
  localparam logic [3:0] IRQ_NMI = 4'hf;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_DBL = 2'h3;

  // decoded instruction class flags from the decoder
  typedef struct packed {
    logic valid;
    logic unimplemented_opcode;
    logic unimpl_int;
    logic wr_cwp;
    logic [4:0] wr_cwp_val;
    logic alt_space;
    logic imm_bit;
    logic return_from_trap;
    logic flush;
    logic priv;
    logic fp_inst;
    logic cp_inst;
    logic save;
    logic restore;
    logic mem;
    logic jump_and_link;
    logic [1:0] size;
    logic [2:0] addr_lo;
    logic tag_trap;
    logic icc_v;
    logic ticc_taken;
    logic [6:0] ticc_num;
  } itd_inst_t;

  typedef struct packed {
    logic s;
    logic ps;
    logic et;
    logic ef;
    logic ec;
    logic [3:0] proc_irq_mask_level;
    logic [2:0] current_window_ptr;
  } itd_psr_t;

endpackage

// ===== rtl/itd_irq_sync.sv
`timescale 1ns/100ps
module itd_irq_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_irq_level_in,
  output logic [3:0] o_level
);
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  logic [3:0] lvl_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 4'h0;
    end else begin
      s1_reg <= i_irq_level_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // disagreeing stages drop the request as a transient
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lvl_reg <= 4'h0;
    end else if (s2_reg == s3_reg) begin // RULE24
      lvl_reg <= s3_reg;
    end else begin
      lvl_reg <= 4'h0; // RULE24
    end
  end

  assign o_level = lvl_reg;

  a_sync_agree: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_level != 4'h0) |-> $past(s2_reg) == $past(s3_reg)) // RULE24
    else $error("irq level taken while stages disagree");
endmodule

// ===== rtl/itd_trap_detect.sv
`timescale 1ns/100ps
// Summary of operation
// RULE1: hold reset while active; on release take reset trap to address 0.
// RULE2: reset keeps trap type field except after illegal user return-from-trap.
// RULE3: reset trap sets supervisor, clears trap enable, keeps others.
// RULE4: memory error on instruction fetch raises instruction access trap.
// RULE5: memory error on data transfer raises data access trap.
// RULE6: unimplemented opcode or integer instruction raises illegal trap.
// RULE7: writing window pointer above 7 raises illegal trap.
// RULE8: alt space immediate, supervisor return_from_trap with traps on, flush off: illegal.
// RULE9: unimplemented float/cop instructions never raise illegal trap.
// RULE10: privileged instruction in user mode raises privileged trap.
// RULE11: float instruction with float disabled or absent traps.
// RULE12: cop instruction with cop disabled or absent traps.
// RULE13: save onto invalid window raises window overflow.
// RULE14: restore onto invalid window raises window underflow.
// RULE15: misaligned double, word, halfword or jump address traps.
// RULE16: pending float exception traps on next float instruction.
// RULE17: pending cop exception traps on next cop instruction.
// RULE18: exception cause comes from unit queue; saved pc is later one.
// RULE19: tagged add/sub with trap setting overflow raises tag overflow.
// RULE20: taken conditional trap instruction raises software trap.
// RULE21: with traps on accept level 15 or level above mask level.
// RULE22: only highest priority pending trap is taken.
// RULE23: trap clears enable, saves supervisor, decrements window, saves pcs.
// RULE24: interrupt level passes two agreeing stages before use.
// RULE25: interrupt trap type is sixteen plus level.
module itd_trap_detect (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire itd_pkg::itd_inst_t i_inst,
  input wire logic [31:0] i_pc,
  input wire logic [31:0] i_npc,
  input wire logic i_ifetch_err,
  input wire logic i_mem_error_in,
  input wire logic i_flush_en,
  input wire logic i_float_present_in,
  input wire logic i_cop_present_in,
  input wire logic i_fp_exc_pend,
  input wire logic i_cp_exc_pend,
  input wire logic [3:0] i_irq_level_in,
  input wire logic [7:0] i_window_invalid_mask,
  input wire logic i_psr_wr,
  input wire itd_pkg::itd_psr_t i_psr_wdata,
  output logic o_trap,
  output logic [7:0] o_trap_type_field,
  output logic o_reset_mode,
  output logic [31:0] o_new_pc,
  output logic [31:0] o_new_npc,
  output logic [31:0] o_saved_pc,
  output logic [31:0] o_saved_npc,
  output logic o_irq_ack,
  output logic o_fp_exc_ack,
  output logic o_cp_exc_ack,
  output itd_pkg::itd_psr_t o_processor_state_reg
);
  itd_pkg::itd_psr_t psr_reg;
  logic [7:0] tt_reg;
  logic in_reset_reg;
  logic bad_return_from_trap_reg;
  logic trap_reg;
  logic irq_ack_reg;
  logic fp_ack_reg;
  logic cp_ack_reg;
  logic [31:0] new_pc_reg;
  logic [31:0] new_npc_reg;
  logic [31:0] sv_pc_reg;
  logic [31:0] sv_npc_reg;
  logic [3:0] irq_lvl;
  logic take;
  logic [7:0] tt_next;
  logic bad_return_from_trap;
  logic v;

  itd_irq_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_irq_level_in(i_irq_level_in),
    .o_level(irq_lvl)
  );

  function automatic logic misaligned(input logic [1:0] sz,
                                      input logic [2:0] a);
    case (sz)
      itd_pkg::SZ_DBL: misaligned = a != 3'h0;
      itd_pkg::SZ_WORD: misaligned = a[1:0] != 2'h0;
      itd_pkg::SZ_HALF: misaligned = a[0];
      default: misaligned = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] cwp_step(input logic [2:0] c,
                                          input logic up);
    cwp_step = up ? c + 3'h1 : c - 3'h1;
  endfunction

  assign v = i_inst.valid && !in_reset_reg;
  assign bad_return_from_trap = v && i_inst.return_from_trap && !psr_reg.et && !psr_reg.s;

  // priority encoder, highest first
  always_comb begin
    take = v;
    tt_next = 8'h00;
    if (v && i_ifetch_err && i_mem_error_in) begin // RULE4 RULE22
      tt_next = itd_pkg::TT_INST_ACCESS;
    end else if (v && (i_inst.unimplemented_opcode // RULE6
        || (i_inst.unimpl_int && !i_inst.fp_inst && !i_inst.cp_inst) // RULE9
        || (i_inst.wr_cwp && i_inst.wr_cwp_val > {2'h0, itd_pkg::CWP_MAX})
        || (i_inst.alt_space && i_inst.imm_bit) // RULE8
        || (i_inst.return_from_trap && psr_reg.et && psr_reg.s)
        || (i_inst.flush && !i_flush_en))) begin // RULE7
      tt_next = itd_pkg::TT_ILLEGAL;
    end else if (v && i_inst.priv && !psr_reg.s) begin // RULE10
      tt_next = itd_pkg::TT_PRIV;
    end else if (v && i_inst.fp_inst
        && (!psr_reg.ef || !i_float_present_in)) begin // RULE11
      tt_next = itd_pkg::TT_FP_DIS;
    end else if (v && i_inst.cp_inst
        && (!psr_reg.ec || !i_cop_present_in)) begin // RULE12
      tt_next = itd_pkg::TT_CP_DIS;
    end else if (v && i_inst.save && i_window_invalid_mask[
        cwp_step(psr_reg.current_window_ptr, 1'b0)]) begin // RULE13
      tt_next = itd_pkg::TT_WIN_OVF;
    end else if (v && i_inst.restore && i_window_invalid_mask[
        cwp_step(psr_reg.current_window_ptr, 1'b1)]) begin // RULE14
      tt_next = itd_pkg::TT_WIN_UNF;
    end else if (v && (i_inst.mem || i_inst.jump_and_link) && misaligned(
        i_inst.jump_and_link ? itd_pkg::SZ_WORD : i_inst.size,
        i_inst.addr_lo)) begin // RULE15
      tt_next = itd_pkg::TT_ALIGN;
    end else if (v && i_inst.fp_inst && i_fp_exc_pend) begin // RULE16
      tt_next = itd_pkg::TT_FP_EXC;
    end else if (v && i_inst.cp_inst && i_cp_exc_pend) begin // RULE17
      tt_next = itd_pkg::TT_CP_EXC;
    end else if (v && i_inst.mem && !i_ifetch_err
        && i_mem_error_in) begin // RULE5
      tt_next = itd_pkg::TT_DATA_ACCESS;
    end else if (v && i_inst.tag_trap && i_inst.icc_v) begin // RULE19
      tt_next = itd_pkg::TT_TAG_OVF;
    end else if (v && i_inst.ticc_taken) begin // RULE20
      tt_next = itd_pkg::TT_SW_BASE | {1'b0, i_inst.ticc_num};
    end else if (v && psr_reg.et && irq_lvl != 4'h0
        && (irq_lvl == itd_pkg::IRQ_NMI
        || irq_lvl > psr_reg.proc_irq_mask_level)) begin // RULE21
      tt_next = itd_pkg::TT_IRQ_BASE | {4'h0, irq_lvl}; // RULE25
    end else begin
      take = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      in_reset_reg <= 1'b1; // RULE1
    end else begin
      in_reset_reg <= 1'b0;
    end
  end

  // remembers a user-mode return-from-trap with traps off
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bad_return_from_trap_reg <= bad_return_from_trap_reg;
    end else if (bad_return_from_trap) begin
      bad_return_from_trap_reg <= 1'b1;
    end else if (take || in_reset_reg) begin // RULE2
      bad_return_from_trap_reg <= 1'b0;
    end
  end

  // processor state; reset release forces s=1 et=0, rest retained
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      psr_reg <= psr_reg;
    end else if (in_reset_reg) begin
      psr_reg.s <= 1'b1; // RULE3
      psr_reg.et <= 1'b0; // RULE3
    end else if (take) begin
      psr_reg.et <= 1'b0; // RULE23
      psr_reg.ps <= psr_reg.s; // RULE23
      psr_reg.s <= 1'b1; // RULE23
      psr_reg.current_window_ptr <= cwp_step(psr_reg.current_window_ptr, 1'b0); // RULE23
    end else if (i_psr_wr) begin
      psr_reg <= i_psr_wdata;
    end
  end

  // trap type is kept across reset unless the return_from_trap case hit
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tt_reg <= tt_reg;
    end else if (in_reset_reg) begin
      tt_reg <= bad_return_from_trap_reg ? 8'h00 : tt_reg; // RULE2
    end else if (take) begin
      tt_reg <= tt_next; // RULE23
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      trap_reg <= 1'b0;
      new_pc_reg <= itd_pkg::RESET_PC;
      new_npc_reg <= itd_pkg::RESET_NPC;
    end else if (in_reset_reg) begin
      trap_reg <= 1'b1; // RULE1
      new_pc_reg <= itd_pkg::RESET_PC; // RULE1
      new_npc_reg <= itd_pkg::RESET_NPC;
    end else begin
      trap_reg <= take;
      new_pc_reg <= i_pc;
      new_npc_reg <= i_npc;
    end
  end

  // saved pc is the instruction that triggered recognition
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sv_pc_reg <= 32'h0000_0000;
      sv_npc_reg <= 32'h0000_0000;
      irq_ack_reg <= 1'b0;
      fp_ack_reg <= 1'b0;
      cp_ack_reg <= 1'b0;
    end else begin
      if (take) begin
        sv_pc_reg <= i_pc; // RULE18 RULE23
        sv_npc_reg <= i_npc; // RULE23
      end
      irq_ack_reg <= take && tt_next[7:4] == 4'h1;
      fp_ack_reg <= take && tt_next == itd_pkg::TT_FP_EXC; // RULE18
      cp_ack_reg <= take && tt_next == itd_pkg::TT_CP_EXC; // RULE18
    end
  end

  assign o_trap = trap_reg;
  assign o_trap_type_field = tt_reg;
  assign o_reset_mode = in_reset_reg;
  assign o_new_pc = new_pc_reg;
  assign o_new_npc = new_npc_reg;
  assign o_saved_pc = sv_pc_reg;
  assign o_saved_npc = sv_npc_reg;
  assign o_irq_ack = irq_ack_reg;
  assign o_fp_exc_ack = fp_ack_reg;
  assign o_cp_exc_ack = cp_ack_reg;
  assign o_processor_state_reg = psr_reg;

  a_reset_vector: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) ##0 in_reset_reg |=> o_trap && o_new_pc == 32'h0000_0000
    && o_processor_state_reg.s && !o_processor_state_reg.et) // RULE1
    else $error("reset trap wrong");
  a_tt_hold_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    in_reset_reg && !bad_return_from_trap_reg |=> $stable(o_trap_type_field)) // RULE2
    else $error("reset changed trap type");
  a_trap_state: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take |=> !o_processor_state_reg.et && o_processor_state_reg.s
    && o_processor_state_reg.current_window_ptr == $past(psr_reg.current_window_ptr) - 3'h1) // RULE23
    else $error("trap state update wrong");
  a_priv_user: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    v && i_inst.priv && !psr_reg.s && !i_mem_error_in
    && !i_inst.unimplemented_opcode && !i_inst.unimpl_int && !i_inst.wr_cwp
    && !i_inst.alt_space && !i_inst.return_from_trap && !i_inst.flush
    |=> o_trap && o_trap_type_field == 8'h03) // RULE10
    else $error("privileged trap missing");
  a_irq_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take && tt_next[7:4] == 4'h1 |-> psr_reg.et
    && (tt_next[3:0] == 4'hf || tt_next[3:0] > psr_reg.proc_irq_mask_level)) // RULE21
    else $error("masked interrupt taken");
  a_irq_tt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_irq_ack |-> o_trap && o_trap_type_field[7:4] == 4'h1
    && o_trap_type_field[3:0] != 4'h0) // RULE25
    else $error("interrupt trap type wrong");
  a_fp_dis: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take && tt_next == 8'h04 |-> i_inst.fp_inst
    && (!psr_reg.ef || !i_float_present_in)) // RULE11
    else $error("float disabled trap wrong");
  a_win_ovf: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take && tt_next == 8'h05 |-> i_inst.save
    && i_window_invalid_mask[psr_reg.current_window_ptr - 3'h1]) // RULE13
    else $error("window overflow wrong");
  a_align: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take && tt_next == 8'h07 && i_inst.size == 2'h1 && !i_inst.jump_and_link
    |-> i_inst.addr_lo[0]) // RULE15
    else $error("halfword alignment wrong");
  a_fp_exc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_fp_exc_ack |-> $past(i_fp_exc_pend) && $past(i_inst.fp_inst)) // RULE16
    else $error("float exception without cause");
  a_tag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    take && tt_next == 8'h0a |-> i_inst.tag_trap && i_inst.icc_v) // RULE19
    else $error("tag overflow without cause");
  a_reset_hold: assert property (@(posedge i_clk)
    !i_rst_n |=> o_reset_mode && !o_trap) // RULE1
    else $error("reset mode not held");
  a_bad_return_from_trap_tt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    in_reset_reg && bad_return_from_trap_reg |=> o_trap_type_field == 8'h00) // RULE2
    else $error("trap type kept after bad return");
  a_inst_access: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    v && i_ifetch_err && i_mem_error_in
    |=> o_trap && o_trap_type_field == itd_pkg::TT_INST_ACCESS) // RULE4
    else $error("instruction access trap missing");
  a_data_trap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    v && i_inst.mem && !i_ifetch_err && i_mem_error_in |=> o_trap) // RULE5
    else $error("data access error not trapped");
  a_cwp_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    v && i_inst.wr_cwp && i_inst.wr_cwp_val > 5'h07
    && !(i_ifetch_err && i_mem_error_in)
    |=> o_trap && o_trap_type_field == itd_pkg::TT_ILLEGAL) // RULE7
    else $error("window pointer write not refused");

  c_reset: cover property (@(posedge i_clk) in_reset_reg ##1 o_trap);
  c_irq: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_irq_ack);
  c_fp: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_fp_exc_ack);
  c_sw: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    take && tt_next[7]);
endmodule

// ===== dv/itd_far_model.sv
`timescale 1ns/100ps
module itd_far_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_fp_raise,
  input wire logic i_cp_raise,
  input wire logic i_fp_exc_ack,
  input wire logic i_cp_exc_ack,
  input wire logic i_irq_load,
  input wire logic [3:0] i_irq_req,
  input wire logic i_irq_ack,
  output logic o_fp_exc_pend,
  output logic o_cp_exc_pend,
  output logic [3:0] o_irq_level_in
);
  // a unit stays pending until the core takes its exception trap
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_fp_exc_ack) begin
      o_fp_exc_pend <= 1'b0;
    end else if (i_fp_raise) begin
      o_fp_exc_pend <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_cp_exc_ack) begin
      o_cp_exc_pend <= 1'b0;
    end else if (i_cp_raise) begin
      o_cp_exc_pend <= 1'b1;
    end
  end

  // level held until reloaded or acknowledged; an acknowledge withdraws it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_irq_ack) begin
      o_irq_level_in <= 4'h0;
    end else if (i_irq_load) begin
      o_irq_level_in <= i_irq_req;
    end
  end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [4:0] env_ok = 5'h07;
  localparam logic [11:0] sup = 12'hb80;
  typedef struct {
    itd_pkg::itd_inst_t n;
    logic [11:0] p;
    logic [7:0] t;
    logic [4:0] e;
    logic [7:0] w;
  } itd_row_t;
  itd_row_t rows[$];
  logic clk, rst_n, psr_wr, fp_r, cp_r, irq_ld, fp_p, cp_p;
  logic trap, rm, ra, fa, ca;
  logic [3:0] irq_q, irq_lv;
  logic [4:0] env;
  logic [7:0] window_invalid_mask, tt;
  logic [31:0] npc0, npc1, spc, snpc, pc;
  itd_pkg::itd_inst_t ins;
  itd_pkg::itd_psr_t psr_wd, psr_o;
  int bad_count = 0;
  int num_checks = 0;

  itd_trap_detect dut (.i_clk(clk), .i_rst_n(rst_n), .i_inst(ins),
    .i_pc(pc), .i_npc(pc + 32'h0000_0004), .i_ifetch_err(env[4]),
    .i_mem_error_in(env[3]), .i_flush_en(env[2]),
    .i_float_present_in(env[1]), .i_cop_present_in(env[0]),
    .i_fp_exc_pend(fp_p), .i_cp_exc_pend(cp_p), .i_irq_level_in(irq_lv),
    .i_window_invalid_mask(window_invalid_mask), .i_psr_wr(psr_wr), .i_psr_wdata(psr_wd),
    .o_trap(trap), .o_trap_type_field(tt), .o_reset_mode(rm),
    .o_new_pc(npc0), .o_new_npc(npc1), .o_saved_pc(spc),
    .o_saved_npc(snpc), .o_irq_ack(ra), .o_fp_exc_ack(fa),
    .o_cp_exc_ack(ca), .o_processor_state_reg(psr_o));

  itd_far_model far (.i_clk(clk), .i_rst_n(rst_n), .i_fp_raise(fp_r),
    .i_cp_raise(cp_r), .i_fp_exc_ack(fa), .i_cp_exc_ack(ca),
    .i_irq_load(irq_ld), .i_irq_req(irq_q), .i_irq_ack(ra),
    .o_fp_exc_pend(fp_p), .o_cp_exc_pend(cp_p), .o_irq_level_in(irq_lv));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one decoded instruction class; a carries the operand fields
  function automatic itd_pkg::itd_inst_t mk(int k, logic [6:0] a = 7'h00);
    itd_pkg::itd_inst_t x;
    x = '0;
    x.valid = 1'b1;
    x.wr_cwp_val = a[4:0];
    x.imm_bit = a[0];
    x.icc_v = a[0];
    x.size = a[5:4];
    x.addr_lo = a[2:0];
    x.ticc_num = a;
    case (k)
      1: x.priv = 1'b1;
      2: x.unimplemented_opcode = 1'b1;
      3: x.unimpl_int = 1'b1;
      4: x.wr_cwp = 1'b1;
      5: x.alt_space = 1'b1;
      6: x.return_from_trap = 1'b1;
      7: x.flush = 1'b1;
      8: x.fp_inst = 1'b1;
      9: x.cp_inst = 1'b1;
      10: x.save = 1'b1;
      11: x.restore = 1'b1;
      12: x.mem = 1'b1;
      13: x.jump_and_link = 1'b1;
      14: x.tag_trap = 1'b1;
      15: x.ticc_taken = 1'b1;
      default: x.valid = 1'b1;
    endcase
    return x;
  endfunction

  // load the state, issue one instruction, check the edge after it
  task automatic run(itd_pkg::itd_inst_t n, logic [11:0] p, logic [7:0] t,
    logic [4:0] e = env_ok, logic [7:0] w = 8'h00);
    itd_pkg::itd_psr_t o;
    o = p;
    @(negedge clk);
    psr_wd = o;
    psr_wr = 1'b1;
    @(negedge clk);
    psr_wr = 1'b0;
    env = e;
    window_invalid_mask = w;
    ins = n;
    pc = pc + 32'h0000_0010;
    @(negedge clk);
    ins.valid = 1'b0;
    env = env_ok;
    chk("trap", t != 8'h00, trap);
    if (t != 8'h00) begin
      chk("type", t, tt);
      chk("state", {1'b1, o.s, 1'b0, o.ef, o.ec, o.proc_irq_mask_level, o.current_window_ptr - 3'h1},
        psr_o);
      chk("saved_pc", pc, spc);
      chk("saved_npc", pc + 32'h0000_0004, snpc);
    end else begin
      chk("state", o, psr_o);
    end
  endtask

  task automatic add(itd_pkg::itd_inst_t n, logic [11:0] p, logic [7:0] t,
    logic [4:0] e = env_ok, logic [7:0] w = 8'h00);
    rows.push_back('{n, p, t, e, w});
  endtask

  task automatic irq(logic [3:0] l, logic [11:0] p, logic [7:0] t);
    @(negedge clk);
    irq_q = l;
    irq_ld = 1'b1;
    @(negedge clk);
    irq_ld = 1'b0;
    repeat (6) @(negedge clk);
    run(mk(0), p, t);
    chk("irq_ack", t != 8'h00, ra);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test;
  end

  initial begin
    rst_n = 1'b0;
    pc = 32'h0000_1000;
    ins = '0;
    env = env_ok;
    window_invalid_mask = 8'h00;
    psr_wr = 1'b0;
    psr_wd = '0;
    fp_r = 1'b0;
    cp_r = 1'b0;
    irq_ld = 1'b0;
    irq_q = 4'h0;
    add(mk(1), 12'h380, 8'h03);
    add(mk(1), sup, 8'h00);
    add(mk(2), sup, 8'h02);
    add(mk(3), sup, 8'h02);
    add(mk(8) | mk(3), sup, 8'h00);
    add(mk(9) | mk(3), sup, 8'h00);
    add(mk(4, 7'h08), sup, 8'h02);
    add(mk(4, 7'h07), sup, 8'h00);
    add(mk(5, 7'h01), sup, 8'h02);
    add(mk(5), sup, 8'h00);
    add(mk(6), sup, 8'h02);
    add(mk(7), sup, 8'h02, 5'h03);
    add(mk(7), sup, 8'h00);
    add(mk(8), 12'ha80, 8'h04);
    add(mk(8), sup, 8'h04, 5'h05);
    add(mk(8), sup, 8'h00);
    add(mk(9), 12'hb00, itd_pkg::TT_CP_DIS);
    add(mk(9), sup, itd_pkg::TT_CP_DIS, 5'h06);
    add(mk(9), sup, 8'h00);
    add(mk(10), sup, 8'h05, env_ok, 8'h80);
    add(mk(10), sup, 8'h00, env_ok, 8'h02);
    add(mk(11), sup, 8'h06, env_ok, 8'h02);
    add(mk(11), sup, 8'h00, env_ok, 8'h80);
    add(mk(12, 7'h22), sup, 8'h07);
    add(mk(12, 7'h34), sup, 8'h07);
    add(mk(12, 7'h11), sup, 8'h07);
    add(mk(12, 7'h30), sup, 8'h00);
    add(mk(12, 7'h12), sup, 8'h00);
    add(mk(13, 7'h22), sup, 8'h07);
    add(mk(12, 7'h20), sup, 8'h09, 5'h0f);
    add(mk(0), sup, 8'h01, 5'h1f);
    add(mk(14, 7'h01), sup, 8'h0a);
    add(mk(14), sup, 8'h00);
    add(mk(15, 7'h05), sup, 8'h85);
    add(mk(1) | mk(2), 12'h380, 8'h02);
    add(mk(2), sup, 8'h01, 5'h1f);
    add(mk(12, 7'h22), sup, 8'h07, 5'h0f);
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) run(rows[i].n, rows[i].p, rows[i].t, rows[i].e,
      rows[i].w);
    for (int u = 0; u < 2; u++) begin
      @(negedge clk);
      fp_r = (u == 0);
      cp_r = (u == 1);
      @(negedge clk);
      fp_r = 1'b0;
      cp_r = 1'b0;
      run(mk(1), sup, 8'h00);
      run(mk(8 + u), sup, u ? itd_pkg::TT_CP_EXC : 8'h08);
      chk("fp_ack", u == 0, fa);
      chk("cp_ack", u == 1, ca);
      run(mk(8 + u), sup, 8'h00);
    end
    irq(4'h5, 12'hba8, 8'h00);
    irq(4'hf, 12'h980, 8'h00);
    irq(4'h6, 12'hba8, 8'h16);
    irq(4'hf, 12'hbf8, 8'h1f);
    @(negedge clk);
    irq_q = 4'h9;
    irq_ld = 1'b1;
    @(negedge clk);
    irq_q = 4'h0;
    @(negedge clk);
    irq_ld = 1'b0;
    repeat (6) @(negedge clk);
    run(mk(0), sup, 8'h00);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    chk("reset_mode", 1'b1, rm);
    chk("trap", 1'b0, trap);
    rst_n = 1'b1;
    @(negedge clk);
    chk("trap", 1'b1, trap);
    chk("new_pc", 32'h0000_0000, npc0);
    chk("new_npc", 32'h0000_0004, npc1);
    chk("type", 8'h1f, tt);
    chk("state", 8'hb0, {psr_o.s, psr_o.et, psr_o.ef, psr_o.ec,
      psr_o.proc_irq_mask_level});
    // user return-from-trap with traps off, then reset clears trap type
    run(mk(6), 12'h180, 8'h00);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("trap", 1'b1, trap);
    chk("type", 8'h00, tt);
    finish_test;
  end
endmodule
